// *** core/rpss_map.vh ***
// Register indices, field positions, reset values and phase lengths
// for the reader power and start-up sequencer.
// Assumes inclusion by bare name from the core files only.
`ifndef RPSS_MAP_VH
`define RPSS_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index).
// ----------------------------------------------------------------
`define RPSS_IDX_PAGE      6'h00
`define RPSS_IDX_COMMAND   6'h01
`define RPSS_IDX_CONTROL   6'h09
`define RPSS_IDX_CFG_FIRST 6'h10
`define RPSS_IDX_CFG_LAST  6'h2F
`define RPSS_IDX_STATUS    6'h3E

// ----------------------------------------------------------------
// Control register fields.
// ----------------------------------------------------------------
`define RPSS_CTL_RX_AUTO   3
`define RPSS_CTL_SOFT      4
`define RPSS_CTL_STANDBY   5

// ----------------------------------------------------------------
// Reset values and command codes.
// ----------------------------------------------------------------
`define RPSS_CONTROL_RST   8'h00
`define RPSS_PAGE_RST      8'h00
`define RPSS_CMD_STARTUP   6'h3F
`define RPSS_CMD_IDLE      6'h00
`define RPSS_PAGE_DETECT   8'h80
`define RPSS_PAGE_LINEAR   8'h00

// ----------------------------------------------------------------
// Phase lengths in clock cycles; standby exit length in crystal rising edges.
// ----------------------------------------------------------------
`define RPSS_RESET_CYCLES  10'd512
`define RPSS_INIT_CYCLES   10'd128
`define RPSS_SOFT_EXIT     10'd512
`define RPSS_STBY_EDGES    3'd4

`endif

// *** core/rpss_sync2.v ***
// Two-flop synchroniser, one chain per bit.
// Assumes d_i comes from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none

module rpss_sync2 #(
	parameter W = 1
) (
	input  wire         clk_i,
	input  wire         rst_n_i,
	input  wire         ce_i,
	input  wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);

	// ----------------------------------------------------------------
	// Synchroniser chains.
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : chain
			reg meta_reg;   // First stage, read only by the second.
			reg stable_reg; // Second stage, safe for logic.
			// Both stages freeze with the clock enable.
			always @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					meta_reg   <= 1'b0;
					stable_reg <= 1'b0;
				end else if (ce_i) begin
					meta_reg   <= d_i[g];
					stable_reg <= meta_reg;
				end
			end
			assign q_o[g] = stable_reg;
		end
	endgenerate

endmodule

`default_nettype wire

// *** core/rpss_cfg_store.v ***
// Configuration register array for subaddresses 10h to 2Fh.
// Assumes one writer at a time, chosen by the sequencer.
`timescale 1ns/100ps
`default_nettype none

module rpss_cfg_store (
	input  wire       clk_i,
	input  wire       ce_i,
	input  wire       we_i,
	input  wire [4:0] waddr_i,
	input  wire [7:0] wdata_i,
	input  wire [4:0] raddr_i,
	output wire [7:0] rdata_o
);

	// ----------------------------------------------------------------
	// Storage.
	// ----------------------------------------------------------------
	reg [7:0] mem_reg [0:31]; // Not reset; the start-up copy fills it.

	// Single write port, frozen with the clock enable.
	always @(posedge clk_i) begin
		if (ce_i && we_i) begin
			mem_reg[waddr_i] <= wdata_i;
		end
	end

	assign rdata_o = mem_reg[raddr_i];

endmodule

`default_nettype wire

// *** core/rpss_sequencer.v ***
// Power-mode and start-up sequencer with an APB register slave.
// Assumes a 100 MHz clock, external pins and supply detectors that
// are asynchronous, and functional output levels from same-clock logic.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "rpss_map.vh"

module rpss_sequencer (
	// Clock, reset and enable.
	input  wire        SYS_CLK_I,
	input  wire        RST_N_I,
	input  wire        CLK_EN_I,
	// APB slave.
	input  wire        PSEL_I,
	input  wire        PENABLE_I,
	input  wire        PWRITE_I,
	input  wire [9:0]  PADDR_I,
	input  wire [31:0] PWDATA_I,
	output wire [31:0] PRDATA_O,
	output wire        PREADY_O,
	output wire        PSLVERR_O,
	// Asynchronous pins and supply detectors.
	input  wire        RESET_SOFT_SLEEP_BIT_PIN_I,
	input  wire        POR_DIGITAL_I,
	input  wire        POR_ANALOG_I,
	input  wire        OSC_STABLE_I,
	input  wire        CRYSTAL_INPUT_PIN_I,
	// Same-clock functional levels and nonvolatile data.
	input  wire        RX_IN_USE_I,
	input  wire        DRIVE_A_I,
	input  wire        DRIVE_B_I,
	input  wire        SIG_MON_I,
	input  wire        IRQ_I,
	input  wire        TEST_MON_I,
	input  wire [7:0]  NV_DATA_I,
	// Pins.
	output wire        ANTENNA_DRIVE_A_O,
	output wire        ANTENNA_DRIVE_B_O,
	output wire        SIGNAL_MONITOR_OUTPUT_O,
	output wire        CRYSTAL_OUTPUT_PIN_O,
	output wire        IRQ_O,
	output wire        IRQ_OE_O,
	output wire        TEST_MONITOR_OUTPUT_O,
	output wire        TEST_MONITOR_OE_O,
	// Power controls and nonvolatile address.
	output wire        CURRENT_SINK_EN_O,
	output wire        OSC_EN_O,
	output wire        OSC_BUF_EN_O,
	output wire        DIG_CLK_EN_O,
	output wire        INPUT_ISOLATE_O,
	output wire        RX_POWER_O,
	output wire [7:0]  NV_ADDR_O
);

	// ----------------------------------------------------------------
	// Phase and detection state codes.
	// ----------------------------------------------------------------
	localparam [2:0] PH_HARD  = 3'h0; // Hard power-down.
	localparam [2:0] PH_OSC   = 3'h1; // Waiting for a stable oscillator.
	localparam [2:0] PH_RESET = 3'h2; // Loading reset values.
	localparam [2:0] PH_INIT  = 3'h3; // Copying configuration.
	localparam [2:0] PH_RUN   = 3'h4; // Idle, under host control.

	localparam [1:0] DET_WAIT = 2'h0; // Waiting for page 80h.
	localparam [1:0] DET_PAGE = 2'h1; // Waiting for command read.
	localparam [1:0] DET_READ = 2'h2; // Waiting for page 00h.
	localparam [1:0] DET_DONE = 2'h3; // Interface detected.

	// ----------------------------------------------------------------
	// Declarations.
	// ----------------------------------------------------------------
	wire [4:0] sync_q;          // Synchronised pins and detectors.
	wire       pin_pd;          // Power-down pin, synchronised.
	wire       osc_ok;          // Oscillator stable, synchronised.
	wire       xtal;            // Crystal input level, synchronised.
	wire       hard_pd;         // Any hard power-down cause.
	reg  [2:0] phase_reg;       // Start-up phase.
	reg  [2:0] phase_next;
	reg  [9:0] cnt_reg;         // Phase cycle counter.
	reg  [9:0] cnt_next;
	reg  [7:0] page_reg;        // Page register.
	reg        rx_auto_reg;     // Receiver auto sleep enable.
	reg        soft_reg;        // Soft sleep bit, also mode flag.
	reg        soft_exit_reg;   // Soft exit countdown running.
	reg  [9:0] soft_cnt_reg;    // Soft exit cycle count.
	reg        stby_reg;        // Standby bit, also mode flag.
	reg        stby_exit_reg;   // Standby exit running.
	reg  [2:0] stby_cnt_reg;    // Crystal edges seen during exit.
	reg        xtal_d_reg;      // Crystal level one cycle ago.
	reg  [1:0] det_reg;         // Interface detection state.
	reg        pready_reg;      // APB ready.
	reg        pslverr_reg;     // APB error.
	reg [31:0] prdata_reg;      // APB read data.
	reg  [7:0] rd_byte;         // Read mux result.
	reg        rd_hit;          // Address is mapped.
	reg        drv_a_reg;       // Pin output registers.
	reg        drv_b_reg;
	reg        sig_reg;
	reg        xout_reg;
	reg        irq_reg;
	reg        irq_oe_reg;
	reg        tmon_reg;
	reg        tmon_oe_reg;
	reg        sink_reg;        // Power control registers.
	reg        osc_en_reg;
	reg        osc_buf_reg;
	reg        dclk_reg;
	reg        iso_reg;
	reg        rx_pwr_reg;
	reg  [7:0] nv_addr_reg;
	wire [5:0] idx;             // Register index from the address.
	wire       setup;           // APB setup cycle.
	wire       access;          // APB access completing now.
	wire       wr_ok;           // Write allowed to act.
	wire [5:0] cmd_val;         // Command register value.
	wire       is_cfg;          // Index lies in the array.
	wire       cp_we;           // Start-up copy write.
	wire       cfg_we;
	wire [4:0] cfg_waddr;
	wire [7:0] cfg_wdata;
	wire [7:0] cfg_rdata;
	wire       frozen;          // Pin outputs hold their state.

	// ----------------------------------------------------------------
	// Input synchronisation.
	// ----------------------------------------------------------------
	// Every asynchronous input passes two flops before use.
	rpss_sync2 #(
		.W (5)
	) u_sync (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RST_N_I),
		.ce_i    (CLK_EN_I),
		.d_i     ({CRYSTAL_INPUT_PIN_I, OSC_STABLE_I, POR_ANALOG_I,
		            POR_DIGITAL_I, RESET_SOFT_SLEEP_BIT_PIN_I}),
		.q_o     (sync_q)
	);

	assign pin_pd  = sync_q[0];
	assign osc_ok  = sync_q[3];
	assign xtal    = sync_q[4];
	assign hard_pd = pin_pd | sync_q[1] | sync_q[2];

	// ----------------------------------------------------------------
	// Start-up phase machine.
	// ----------------------------------------------------------------
	// A pulse on the pin that the synchroniser misses cannot start a
	// new reset; the host keeps it long enough.
	always @* begin
		phase_next = phase_reg;
		cnt_next   = cnt_reg;
		case (phase_reg)
			PH_HARD: begin
				cnt_next = 10'h000;
				if (!hard_pd) begin
					phase_next = PH_OSC;
				end
			end
			PH_OSC: begin
				if (osc_ok) begin
					phase_next = PH_RESET;
				end
			end
			PH_RESET: begin
				if (cnt_reg == `RPSS_RESET_CYCLES - 10'd1) begin
					phase_next = PH_INIT;
					cnt_next   = 10'h000;
				end else begin
					cnt_next = cnt_reg + 10'd1;
				end
			end
			PH_INIT: begin
				if (cnt_reg == `RPSS_INIT_CYCLES - 10'd1) begin
					phase_next = PH_RUN;
					cnt_next   = 10'h000;
				end else begin
					cnt_next = cnt_reg + 10'd1;
				end
			end
			PH_RUN: begin
				phase_next = PH_RUN;
			end
			default: begin
				phase_next = PH_HARD;
				cnt_next   = 10'h000;
			end
		endcase
		// Hard power-down overrides every phase.
		if (hard_pd) begin
			phase_next = PH_HARD;
			cnt_next   = 10'h000;
		end
	end

	// Phase registers.
	always @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			phase_reg <= PH_HARD;
			cnt_reg   <= 10'h000;
		end else if (CLK_EN_I) begin
			phase_reg <= phase_next;
			cnt_reg   <= cnt_next;
		end
	end

	// ----------------------------------------------------------------
	// Configuration copy.
	// ----------------------------------------------------------------
	// One byte every four cycles fills 32 bytes in 128 cycles; the
	// address is set three cycles before the byte is taken.
	assign cp_we     = (phase_reg == PH_INIT) && (cnt_reg[1:0] == 2'h3);
	assign is_cfg    = (idx >= `RPSS_IDX_CFG_FIRST) && (idx <= `RPSS_IDX_CFG_LAST);
	assign cfg_we    = cp_we | (wr_ok & is_cfg);
	// Copy slot k lands at subaddress 10h + k, which is the entry that a
	// host read of that subaddress selects through idx[4:0].
	assign cfg_waddr = cp_we ? (cnt_reg[6:2] ^ 5'h10) : idx[4:0];
	assign cfg_wdata = cp_we ? NV_DATA_I : PWDATA_I[7:0];

	rpss_cfg_store u_cfg (
		.clk_i   (SYS_CLK_I),
		.ce_i    (CLK_EN_I),
		.we_i    (cfg_we),
		.waddr_i (cfg_waddr),
		.wdata_i (cfg_wdata),
		.raddr_i (idx[4:0]),
		.rdata_o (cfg_rdata)
	);

	// Nonvolatile address follows the copy position.
	always @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			nv_addr_reg <= 8'h10;
		end else if (CLK_EN_I) begin
			nv_addr_reg <= {3'h0, cnt_reg[6:2]} + 8'h10;
		end
	end

	// ----------------------------------------------------------------
	// APB decode.
	// ----------------------------------------------------------------
	assign idx    = PADDR_I[7:2];
	assign setup  = PSEL_I & ~PENABLE_I;
	assign access = PSEL_I & PENABLE_I & pready_reg;
	// Before idle no register may change, the page register included.
	assign wr_ok  = access & PWRITE_I & (phase_reg == PH_RUN);
	assign cmd_val = ((phase_reg == PH_RESET) || (phase_reg == PH_INIT)) ?
	                 `RPSS_CMD_STARTUP : `RPSS_CMD_IDLE;

	// Read mux, unmapped indices flag an error.
	always @* begin
		rd_byte = 8'h00;
		rd_hit  = 1'b1;
		if (is_cfg) begin
			rd_byte = cfg_rdata;
		end else begin
			case (idx)
				`RPSS_IDX_PAGE:    rd_byte = page_reg;
				`RPSS_IDX_COMMAND: rd_byte = {2'h0, cmd_val};
				`RPSS_IDX_CONTROL: rd_byte = {2'h0, stby_reg, soft_reg,
				                              rx_auto_reg, 3'h0};
				`RPSS_IDX_STATUS:  rd_byte = {det_reg, stby_exit_reg,
				                              soft_exit_reg, 1'b0, phase_reg};
				default:           rd_hit  = 1'b0;
			endcase
		end
	end

	// Zero wait states: answer is ready in the access cycle. Inputs
	// are isolated in hard power-down, so reads then return zero.
	always @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else if (CLK_EN_I) begin
			pready_reg  <= setup;
			pslverr_reg <= setup & ~rd_hit;
			if (setup && !PWRITE_I && phase_reg != PH_HARD) begin
				prdata_reg <= {24'h000000, rd_byte};
			end else if (setup) begin
				prdata_reg <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Page register and interface detection.
	// ----------------------------------------------------------------
	// Page writes are allowed only in the idle phase, which is also
	// where the detection sequence uses them.
	always @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			page_reg <= `RPSS_PAGE_RST;
			det_reg  <= DET_WAIT;
		end else if (CLK_EN_I) begin
			if (phase_reg != PH_RUN) begin
				page_reg <= `RPSS_PAGE_RST;
				det_reg  <= DET_WAIT;
			end else if (access && idx == `RPSS_IDX_PAGE && PWRITE_I) begin
				page_reg <= PWDATA_I[7:0];
				case (det_reg)
					DET_WAIT: begin
						if (PWDATA_I[7:0] == `RPSS_PAGE_DETECT) begin
							det_reg <= DET_PAGE;
						end
					end
					DET_READ: begin
						if (PWDATA_I[7:0] == `RPSS_PAGE_LINEAR) begin
							det_reg <= DET_DONE;
						end
					end
					default: begin
						det_reg <= det_reg;
					end
				endcase
			end else if (access && idx == `RPSS_IDX_COMMAND && !PWRITE_I &&
			             det_reg == DET_PAGE) begin
				det_reg <= DET_READ;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control register with soft sleep and standby exits.
	// ----------------------------------------------------------------
	// Both mode bits stay set until the exit finishes, so software can
	// poll them instead of timing the wake-up itself.
	always @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rx_auto_reg   <= 1'b0; // Control reset value has this bit clear.
			soft_reg      <= 1'b0;
			soft_exit_reg <= 1'b0;
			soft_cnt_reg  <= 10'h000;
			stby_reg      <= 1'b0;
			stby_exit_reg <= 1'b0;
			stby_cnt_reg  <= 3'h0;
			xtal_d_reg    <= 1'b0;
		end else if (CLK_EN_I) begin
			xtal_d_reg <= xtal;
			if (phase_reg != PH_RUN) begin
				rx_auto_reg   <= 1'b0;
				soft_reg      <= 1'b0;
				soft_exit_reg <= 1'b0;
				stby_reg      <= 1'b0;
				stby_exit_reg <= 1'b0;
			end else begin
				if (wr_ok && idx == `RPSS_IDX_CONTROL) begin
					rx_auto_reg <= PWDATA_I[`RPSS_CTL_RX_AUTO];
					if (PWDATA_I[`RPSS_CTL_SOFT]) begin
						soft_reg      <= 1'b1;
						soft_exit_reg <= 1'b0;
					end else if (soft_reg && !soft_exit_reg) begin
						soft_exit_reg <= 1'b1;
						soft_cnt_reg  <= 10'h000;
					end
					if (PWDATA_I[`RPSS_CTL_STANDBY]) begin
						stby_reg      <= 1'b1;
						stby_exit_reg <= 1'b0;
					end else if (stby_reg && !stby_exit_reg) begin
						stby_exit_reg <= 1'b1;
						stby_cnt_reg  <= 3'h0;
					end
				end else begin
					// Soft exit: count cycles, then clear the bit.
					if (soft_exit_reg) begin
						if (soft_cnt_reg == `RPSS_SOFT_EXIT - 10'd1) begin
							soft_reg      <= 1'b0;
							soft_exit_reg <= 1'b0;
						end else begin
							soft_cnt_reg <= soft_cnt_reg + 10'd1;
						end
					end
					// Standby exit: count crystal rising edges.
					if (stby_exit_reg && xtal && !xtal_d_reg) begin
						if (stby_cnt_reg == `RPSS_STBY_EDGES - 3'd1) begin
							stby_reg      <= 1'b0;
							stby_exit_reg <= 1'b0;
						end else begin
							stby_cnt_reg <= stby_cnt_reg + 3'd1;
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin levels and power controls.
	// ----------------------------------------------------------------
	assign frozen = soft_reg | stby_reg;

	// Hard power-down forces fixed levels; low-power modes hold the
	// last levels, since outputs must not glitch while asleep.
	always @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			drv_a_reg   <= 1'b1;
			drv_b_reg   <= 1'b0;
			sig_reg     <= 1'b0;
			xout_reg    <= 1'b1;
			irq_reg     <= 1'b0;
			irq_oe_reg  <= 1'b0;
			tmon_reg    <= 1'b0;
			tmon_oe_reg <= 1'b0;
			sink_reg    <= 1'b0;
			osc_en_reg  <= 1'b0;
			osc_buf_reg <= 1'b0;
			dclk_reg    <= 1'b0;
			iso_reg     <= 1'b1;
			rx_pwr_reg  <= 1'b0;
		end else if (CLK_EN_I) begin
			if (phase_reg == PH_HARD) begin
				drv_a_reg   <= 1'b1;
				drv_b_reg   <= 1'b0;
				sig_reg     <= 1'b0;
				xout_reg    <= 1'b1;
				irq_oe_reg  <= 1'b0;
				tmon_oe_reg <= 1'b0;
			end else if (!frozen) begin
				drv_a_reg   <= DRIVE_A_I;
				drv_b_reg   <= DRIVE_B_I;
				sig_reg     <= SIG_MON_I;
				xout_reg    <= ~xtal;
				irq_reg     <= IRQ_I;
				irq_oe_reg  <= 1'b1;
				tmon_reg    <= TEST_MON_I;
				tmon_oe_reg <= 1'b1;
			end
			sink_reg    <= (phase_reg != PH_HARD) & ~frozen;
			osc_en_reg  <= (phase_reg != PH_HARD);
			osc_buf_reg <= (phase_reg != PH_HARD) & ~soft_reg;
			dclk_reg    <= (phase_reg != PH_HARD) & ~stby_reg;
			iso_reg     <= (phase_reg == PH_HARD);
			rx_pwr_reg  <= (phase_reg == PH_RUN) & ~frozen &
			               (~rx_auto_reg | RX_IN_USE_I);
		end
	end

	// ----------------------------------------------------------------
	// Output assignments.
	// ----------------------------------------------------------------
	assign PRDATA_O                = prdata_reg;
	assign PREADY_O                = pready_reg;
	assign PSLVERR_O               = pslverr_reg;
	assign ANTENNA_DRIVE_A_O       = drv_a_reg;
	assign ANTENNA_DRIVE_B_O       = drv_b_reg;
	assign SIGNAL_MONITOR_OUTPUT_O = sig_reg;
	assign CRYSTAL_OUTPUT_PIN_O    = xout_reg;
	assign IRQ_O                   = irq_reg;
	assign IRQ_OE_O                = irq_oe_reg;
	assign TEST_MONITOR_OUTPUT_O   = tmon_reg;
	assign TEST_MONITOR_OE_O       = tmon_oe_reg;
	assign CURRENT_SINK_EN_O       = sink_reg;
	assign OSC_EN_O                = osc_en_reg;
	assign OSC_BUF_EN_O            = osc_buf_reg;
	assign DIG_CLK_EN_O            = dclk_reg;
	assign INPUT_ISOLATE_O         = iso_reg;
	assign RX_POWER_O              = rx_pwr_reg;
	assign NV_ADDR_O               = nv_addr_reg;

endmodule

`default_nettype wire

// *** tb/rpss_nv_model.sv ***
// Nonvolatile store model feeding the start-up copy.
// Assumes the sequencer holds the address steady while it copies.
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Store model
// ------------------------------------------------------------
module rpss_nv_model (
	// Address from the copy engine.
	input  wire logic [7:0] nv_addr_i,
	// Byte at that address.
	output var  logic [7:0] nv_data_o
);
	// Each byte depends on its address, so a slipped copy index shows up.
	always_comb begin
		nv_data_o = nv_addr_i ^ 8'h5A;
	end
endmodule

`default_nettype wire

// *** tb/rpss_sequencer_props.sv ***
// Port checker for the power and start-up sequencer.
// Assumes one clock domain and the top module's port names.
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module rpss_sequencer_props (
	input wire logic        SYS_CLK_I,
	input wire logic        RST_N_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic [9:0]  PADDR_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	input wire logic        ANTENNA_DRIVE_A_O,
	input wire logic        ANTENNA_DRIVE_B_O,
	input wire logic        SIGNAL_MONITOR_OUTPUT_O,
	input wire logic        CRYSTAL_OUTPUT_PIN_O,
	input wire logic        IRQ_OE_O,
	input wire logic        TEST_MONITOR_OE_O,
	input wire logic        CURRENT_SINK_EN_O,
	input wire logic        OSC_EN_O,
	input wire logic        INPUT_ISOLATE_O,
	input wire logic [7:0]  NV_ADDR_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);
	// Pins settle in the same cycle that isolation begins; the past term skips that first cycle.
	a_hard_pins: assert property (INPUT_ISOLATE_O && $past(INPUT_ISOLATE_O) |-> ANTENNA_DRIVE_A_O
		&& !ANTENNA_DRIVE_B_O && !SIGNAL_MONITOR_OUTPUT_O && CRYSTAL_OUTPUT_PIN_O && !IRQ_OE_O && !TEST_MONITOR_OE_O)
		else $error("pin level wrong in hard power-down");
	a_hard_osc_off: assert property (INPUT_ISOLATE_O && $past(INPUT_ISOLATE_O) |-> !OSC_EN_O && !CURRENT_SINK_EN_O)
		else $error("oscillator or sinks on in hard power-down");
	a_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
		else $error("no ready in access cycle");
	a_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready longer than one cycle");
	a_err_with_ready: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error without ready");
	a_unmapped_err: assert property (PSEL_I && !PENABLE_I && PADDR_I[7:2] == 6'h05 |=> PSLVERR_O && PRDATA_O == 32'h0)
		else $error("unmapped access not refused");
	a_rdata_upper: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_nv_window: assert property (NV_ADDR_O >= 8'h10 && NV_ADDR_O <= 8'h2F)
		else $error("copy address outside window");
endmodule

bind rpss_sequencer rpss_sequencer_props u_rpss_sequencer_props (.*);

`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the power and start-up sequencer.
// Assumes core files, store model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module tb_top;
	logic        clk, rst_n, psel, penable, pwrite, pin_pd, por_d, por_a, xtal, rx_use;
	logic        pready, pslverr, iso, sink, osc, obuf, dclk, rxp, a, b, sig, xo, ioe, toe;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [4:0]  fn;
	logic [7:0]  nva, nvd, r, d;
	logic [8:0]  expq[$];
	int          fails, n_tests, cyc, t0, i;

	rpss_sequencer u_rpss_sequencer (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .RESET_SOFT_SLEEP_BIT_PIN_I(pin_pd),
		.POR_DIGITAL_I(por_d), .POR_ANALOG_I(por_a), .OSC_STABLE_I(1'b1), .CRYSTAL_INPUT_PIN_I(xtal),
		.RX_IN_USE_I(rx_use), .DRIVE_A_I(fn[0]), .DRIVE_B_I(fn[1]), .SIG_MON_I(fn[2]), .IRQ_I(fn[3]),
		.TEST_MON_I(fn[4]), .NV_DATA_I(nvd), .ANTENNA_DRIVE_A_O(a), .ANTENNA_DRIVE_B_O(b),
		.SIGNAL_MONITOR_OUTPUT_O(sig), .CRYSTAL_OUTPUT_PIN_O(xo), .IRQ_O(), .IRQ_OE_O(ioe),
		.TEST_MONITOR_OUTPUT_O(), .TEST_MONITOR_OE_O(toe), .CURRENT_SINK_EN_O(sink), .OSC_EN_O(osc),
		.OSC_BUF_EN_O(obuf), .DIG_CLK_EN_O(dclk), .INPUT_ISOLATE_O(iso), .RX_POWER_O(rxp), .NV_ADDR_O(nva));
	rpss_nv_model u_rpss_nv_model (.nv_addr_i(nva), .nv_data_o(nvd));

	// Free-running clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Cycle count, random functional levels and the hang limit.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		fn <= 5'($urandom);
		if (cyc == 40000) begin
			fails++;
			tally_and_finish();
		end
	end

	// Read monitor: pops the oldest note when a read completes.
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (expq.size() > 0 && expq[0][8]) chk(prdata, {24'h0, expq[0][7:0]});
			if (expq.size() > 0) expq.pop_front();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; entered just after an edge, leaves just after one.
	task automatic apb(input logic w, input logic [5:0] ix, input logic [7:0] dv);
		int n;
		n = 0;
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {2'b0, ix, 2'b0}; pwdata <= {24'h0, dv};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) fails++;
		r = prdata[7:0];
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [5:0] ix, input logic [7:0] dv);
		apb(1'b1, ix, dv);
	endtask

	task automatic rd(input logic [5:0] ix, input logic [7:0] e, input logic c);
		expq.push_back({c, e});
		apb(1'b0, ix, 8'h00);
	endtask

	task automatic poll(input logic [5:0] ix, input logic [7:0] v);
		int k;
		k = 0;
		do begin
			rd(ix, 8'h00, 1'b0);
			k++;
		end while (r !== v && k < 3000);
	endtask

	task automatic cy(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One crystal period, slow against the system clock.
	task automatic tick();
		xtal <= 1'b1;
		cy(4);
		xtal <= 1'b0;
		cy(4);
	endtask

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Main sequence: start-up, detection, modes, then hard power-down.
	initial begin
		void'($urandom(75012));
		{rst_n, psel, penable, pwrite, pin_pd, por_d, por_a, xtal, rx_use, fn} = '0;
		{paddr, pwdata, cyc, fails, n_tests} = '0;
		cy(5);
		rst_n <= 1'b1;
		cy(1);
		poll(6'h01, 8'h3F);
		t0 = cyc;
		wr(6'h09, 8'h10);
		poll(6'h01, 8'h00);
		chk(32'(cyc - t0 >= 630 && cyc - t0 <= 650), 32'h1);
		rd(6'h09, 8'h00, 1'b1);
		for (i = 0; i < 32; i++) rd(6'(16 + i), 8'(16 + i) ^ 8'h5A, 1'b1);
		wr(6'h00, 8'h80);
		rd(6'h01, 8'h00, 1'b1);
		wr(6'h00, 8'h00);
		rd(6'h3E, 8'hC4, 1'b1);
		d = 8'($urandom);
		wr(6'h2F, d);
		rd(6'h2F, d, 1'b1);
		rd(6'h05, 8'h00, 1'b1);
		wr(6'h09, 8'h10);
		cy(2);
		chk({30'h0, obuf, sink}, 32'h0);
		wr(6'h09, 8'h00);
		rd(6'h09, 8'h10, 1'b1);
		t0 = cyc;
		poll(6'h09, 8'h00);
		chk(32'(cyc - t0 >= 500 && cyc - t0 <= 515), 32'h1);
		wr(6'h09, 8'h20);
		cy(2);
		chk({30'h0, dclk, obuf}, 32'h1);
		wr(6'h09, 8'h00);
		repeat (3) tick();
		rd(6'h09, 8'h20, 1'b1);
		tick();
		rd(6'h09, 8'h00, 1'b1);
		wr(6'h09, 8'h08);
		cy(3);
		chk({31'h0, rxp}, 32'h0);
		rx_use <= 1'b1;
		cy(3);
		chk({31'h0, rxp}, 32'h1);
		rx_use <= 1'b0;
		wr(6'h09, 8'h00);
		cy(3);
		chk({31'h0, rxp}, 32'h1);
		pin_pd <= 1'b1;
		cy(20);
		chk({26'h0, iso, osc, sink, a, b, xo}, 32'h25);
		pin_pd <= 1'b0;
		por_a <= 1'b1;
		cy(20);
		chk({31'h0, iso}, 32'h1);
		por_a <= 1'b0;
		por_d <= 1'b1;
		cy(20);
		chk({31'h0, iso}, 32'h1);
		por_d <= 1'b0;
		poll(6'h01, 8'h3F);
		poll(6'h01, 8'h00);
		rd(6'h3E, 8'h04, 1'b1);
		tally_and_finish();
	end
endmodule

`default_nettype wire
